// ### asp_regs.vh
// Register offsets, field positions and counts for the serial port pair
`ifndef ASP_REGS_VH
`define ASP_REGS_VH
// Register byte offsets
`define ASP_OFF_CTL0 8'h00
`define ASP_OFF_BUF0 8'h04
`define ASP_OFF_CTL1 8'h08
`define ASP_OFF_BUF1 8'h0C
`define ASP_OFF_PWR  8'h10
// Serial control field positions
`define ASP_B_RI  0
`define ASP_B_TI  1
`define ASP_B_RB8 2
`define ASP_B_TB8 3
`define ASP_B_REN 4
`define ASP_B_AF  5
`define ASP_B_MLO 6
`define ASP_B_MHI 7
// Power control field positions
`define ASP_B_DBL   7
`define ASP_B_FESEL 6
// Reset values
`define ASP_RST_BYTE 8'h00
`define ASP_RST_BUF  8'h00
// Mode codes
`define ASP_MODE0 2'h0
`define ASP_MODE2 2'h2
// Divide-by-16 counter and vote sample states
`define ASP_DIV_LAST 4'hF
`define ASP_SMP_A    4'h7
`define ASP_SMP_B    4'h8
`define ASP_SMP_C    4'h9
// Frame lengths in bits
`define ASP_FRAME10 4'hA
`define ASP_FRAME11 4'hB
// Source events per 16x tick, minus one
`define ASP_OSC_FAST 2'h1
`define ASP_OSC_SLOW 2'h3
`define ASP_TMR_FAST 2'h0
`define ASP_TMR_SLOW 2'h1
// AXI responses
`define ASP_RESP_OK  2'h0
`define ASP_RESP_ERR 2'h2
`endif

// ### asp_tick.v
// Sixteen-times baud tick divider
`timescale 1ns/10ps
`include "asp_regs.vh"
module asp_tick (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       src,
	input  wire [1:0] last,
	output reg        tick
);
	// Source events counted so far
	reg [1:0] cnt;

	// One tick per last+1 source events
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt  <= 2'h0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (src) begin
				if (cnt >= last) begin
					cnt  <= 2'h0;
					tick <= 1'b1;
				end else begin
					cnt <= cnt + 2'h1;
				end
			end
		end
	end
endmodule

// ### asp_sync.v
// Two-stage synchroniser for a serial input pin
`timescale 1ns/10ps
module asp_sync (
	input  wire aclk,
	input  wire aresetn,
	input  wire d,
	output reg  q
);
	// First stage, read only by q
	reg meta;

	// Idle line level is high
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta <= 1'b1;
			q    <= 1'b1;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ### asp_top.v
// Two asynchronous serial ports behind an AXI4-Lite slave
`timescale 1ns/10ps
`include "asp_regs.vh"
// What this block does
// RULE1 - Mode 1: start, eight LSB-first, stop
// RULE2 - Mode 1 stop bit lands in ninth field
// RULE3 - Mode 1 rate: timer overflow/16 or /32
// RULE4 - Each bit leaves at divider rollover
// RULE5 - Mode 1 transmit flag at tenth rollover
// RULE6 - Receive on falling edge, enable high
// RULE7 - Edge restarts receive divide-by-16 counter
// RULE8 - Majority vote over states 8,9,10
// RULE9 - Non-zero start bit aborts reception
// RULE10 - Load only if flag clear, filter passes
// RULE11 - Mid stop bit returns to edge hunting
// RULE12 - Modes 2/3: eleven bits with ninth
// RULE13 - Mode 2 rate: clock/32 or /64
// RULE14 - Mode 2 transmit flag at eleventh rollover
// RULE15 - Received ninth bit to ninth field
// RULE16 - Mode 3 like mode 2, timer rate
// RULE17 - Mode bits pick the frame format
// RULE18 - Buffer write starts transmission
// RULE19 - Missing stop bit sets frame error
// RULE20 - Frame error cleared only by software
// RULE21 - Control bit 7 shared via select
// RULE22 - Buffer write transmits, read receives
// RULE23 - Flags stay set until software clears
// RULE24 - Second port duplicates all behaviour
module asp_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        timer_overflow,
	input  wire        serial_in0,
	input  wire        serial_in1,
	output wire        serial_out0,
	output wire        serial_out1
);
	// Any of the five mapped words
	function asp_mapped;
		input [7:0] a;
		begin
			asp_mapped = (a == `ASP_OFF_CTL0) | (a == `ASP_OFF_BUF0) |
				(a == `ASP_OFF_CTL1) | (a == `ASP_OFF_BUF1) |
				(a == `ASP_OFF_PWR);
		end
	endfunction

	// Two of three vote
	function asp_maj;
		input a;
		input b;
		input c;
		begin
			asp_maj = (a & b) | (a & c) | (b & c);
		end
	endfunction

	// Ninth bit and data byte from the receive shifter
	function [8:0] asp_unpack;
		input [8:0] sh;
		input       w11;
		begin
			asp_unpack = w11 ? sh : {1'b0, sh[8:1]};
		end
	endfunction

	// Write channel capture
	reg        aw_ok;   // Address held
	reg        w_ok;    // Data held
	reg  [7:0] aw_addr; // Held address
	reg  [7:0] w_byte;  // Held low data byte
	reg        w_lane;  // Low byte lane enabled
	// Power control bits shared by both ports
	reg        baud_doubler;
	reg        frame_error_access_select;

	// Write commits once address and data are both held
	wire       do_wr  = aw_ok & w_ok & ~s_axi_bvalid;
	wire       wr_lo  = do_wr & w_lane;
	wire [1:0] wr_ctl = {wr_lo & (aw_addr == `ASP_OFF_CTL1),
		wr_lo & (aw_addr == `ASP_OFF_CTL0)};
	wire [1:0] wr_buf = {wr_lo & (aw_addr == `ASP_OFF_BUF1),
		wr_lo & (aw_addr == `ASP_OFF_BUF0)};
	wire       wr_pwr = wr_lo & (aw_addr == `ASP_OFF_PWR);
	// Per-port readback and pins
	wire [15:0] ctl_rd;  // Control bytes
	wire [15:0] buf_rd;  // Receive buffer bytes
	wire [1:0]  in_pins = {serial_in1, serial_in0};
	wire [1:0]  pin_out; // Transmit pin flops

	// Write address, write data and response channels
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok         <= 1'b0;
			w_ok          <= 1'b0;
			aw_addr       <= 8'h00;
			w_byte        <= 8'h00;
			w_lane        <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ASP_RESP_OK;
		end else begin
			// Either order of address and data
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok         <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok         <= 1'b1;
				w_byte       <= s_axi_wdata[7:0];
				w_lane       <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			// Commit and answer
			if (do_wr) begin
				aw_ok        <= 1'b0;
				w_ok         <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= asp_mapped(aw_addr) ?
					`ASP_RESP_OK : `ASP_RESP_ERR;
			end
			// Response taken, reopen both channels
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read address and data channels
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `ASP_RESP_OK;
			s_axi_rdata   <= 32'h00000000;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= asp_mapped(s_axi_araddr) ?
					`ASP_RESP_OK : `ASP_RESP_ERR;
				// Buffer reads return the receive side RULE22
				case (s_axi_araddr)
					`ASP_OFF_CTL0: s_axi_rdata <= {24'h000000, ctl_rd[7:0]};
					`ASP_OFF_BUF0: s_axi_rdata <= {24'h000000, buf_rd[7:0]};
					`ASP_OFF_CTL1: s_axi_rdata <= {24'h000000, ctl_rd[15:8]};
					`ASP_OFF_BUF1: s_axi_rdata <= {24'h000000, buf_rd[15:8]};
					`ASP_OFF_PWR: s_axi_rdata <= {24'h000000, baud_doubler,
						frame_error_access_select, 6'h00};
					default: s_axi_rdata <= 32'h00000000;
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Power control register
	always @(posedge aclk) begin
		if (!aresetn) begin
			baud_doubler              <= 1'b0;
			frame_error_access_select <= 1'b0;
		end else if (wr_pwr) begin
			baud_doubler              <= w_byte[`ASP_B_DBL];
			frame_error_access_select <= w_byte[`ASP_B_FESEL];
		end
	end

	// One identical engine per port RULE24
	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_port
			// Control fields
			reg       mode_select_hi;
			reg       mode_select_lo;
			reg       address_filter_bit;
			reg       rx_enable;
			reg       tx_ninth_bit;
			reg       rx_ninth_bit;
			reg       transmit_flag;
			reg       receive_flag;
			reg       frame_error_flag;
			reg [7:0] rx_buf;    // Receive buffer
			// Transmit side
			reg [10:0] tx_sh;    // Frame shifter
			reg [3:0]  tx_left;  // Bits still to drive
			reg [3:0]  tx_div;   // Divide-by-16 counter
			reg        tx_out;   // Pin flop
			// Receive side
			reg        rx_on;    // Frame in progress
			reg [3:0]  rx_div;   // Divide-by-16 counter
			reg [3:0]  rx_idx;   // Bits decided so far
			reg [8:0]  rx_sh;    // Data shifter
			reg        smp_a;    // Sample at state 8
			reg        smp_b;    // Sample at state 9
			reg        prev;     // Pin at last tick

			// Mode and frame shape RULE17
			wire [1:0] mode   = {mode_select_lo, mode_select_hi};
			wire       is11   = mode[1];
			wire       active = (mode != `ASP_MODE0);
			wire [3:0] flen   = is11 ? `ASP_FRAME11 : `ASP_FRAME10;
			wire       tick;     // 16x bit rate enable
			wire       pin;      // Synchronised input
			// Clock source for mode 2, timer otherwise RULE13 RULE16
			wire       src = (mode == `ASP_MODE2) ? 1'b1 : timer_overflow;
			// Doubler halves the divide RULE3
			wire [1:0] last = (mode == `ASP_MODE2) ?
				(baud_doubler ? `ASP_OSC_FAST : `ASP_OSC_SLOW) :
				(baud_doubler ? `ASP_TMR_FAST : `ASP_TMR_SLOW);
			wire       roll   = tick & (tx_div == `ASP_DIV_LAST);
			wire       smp_end = tick & rx_on & (rx_div == `ASP_SMP_C);
			wire       bit_v  = asp_maj(smp_a, smp_b, pin); // RULE8
			wire       last_bit = (rx_idx == flen - 4'h1);
			wire [8:0] got    = asp_unpack(rx_sh, is11);
			wire       rx_done = smp_end & last_bit;
			// Load gate on flag and filter RULE10
			wire       rx_load = rx_done & ~receive_flag &
				(~address_filter_bit | bit_v);
			// Flag on the rollover that drives stop RULE5 RULE14
			wire       ti_set = roll & (tx_left == 4'h1);
			wire       fe_set = rx_done & ~bit_v; // RULE19

			// Baud tick divider
			asp_tick u_tick (
				.aclk    (aclk),
				.aresetn (aresetn),
				.src     (src),
				.last    (last),
				.tick    (tick)
			);

			// Input pin synchroniser
			asp_sync u_sync (
				.aclk    (aclk),
				.aresetn (aresetn),
				.d       (in_pins[p]),
				.q       (pin)
			);

			// Control register and flags
			always @(posedge aclk) begin
				if (!aresetn) begin
					mode_select_hi     <= 1'b0;
					mode_select_lo     <= 1'b0;
					address_filter_bit <= 1'b0;
					rx_enable          <= 1'b0;
					tx_ninth_bit       <= 1'b0;
					rx_ninth_bit       <= 1'b0;
					transmit_flag      <= 1'b0;
					receive_flag       <= 1'b0;
					frame_error_flag   <= 1'b0;
					rx_buf             <= `ASP_RST_BUF;
				end else begin
					if (wr_ctl[p]) begin
						// Bit 7 goes to mode only when select is low
						if (!frame_error_access_select)
							mode_select_hi <= w_byte[`ASP_B_MHI]; // RULE21
						mode_select_lo     <= w_byte[`ASP_B_MLO];
						address_filter_bit <= w_byte[`ASP_B_AF];
						rx_enable          <= w_byte[`ASP_B_REN];
						tx_ninth_bit       <= w_byte[`ASP_B_TB8];
					end
					// Hardware load beats a software write
					if (rx_load) begin
						rx_ninth_bit <= is11 ? got[8] : bit_v; // RULE2 RULE15
						rx_buf       <= got[7:0];
					end else if (wr_ctl[p]) begin
						rx_ninth_bit <= w_byte[`ASP_B_RB8];
					end
					// Set wins over a clearing write RULE23
					transmit_flag <= ti_set |
						(wr_ctl[p] ? w_byte[`ASP_B_TI] : transmit_flag);
					receive_flag <= rx_load |
						(wr_ctl[p] ? w_byte[`ASP_B_RI] : receive_flag);
					// Software may only clear the error RULE20 RULE21
					frame_error_flag <= fe_set |
						((wr_ctl[p] & frame_error_access_select) ?
						(frame_error_flag & w_byte[`ASP_B_MHI]) :
						frame_error_flag);
				end
			end

			// Transmitter, paced by its divide-by-16 counter
			always @(posedge aclk) begin
				if (!aresetn) begin
					tx_sh   <= 11'h7FF;
					tx_left <= 4'h0;
					tx_div  <= 4'h0;
					tx_out  <= 1'b1;
				end else begin
					if (tick)
						tx_div <= tx_div + 4'h1;
					// Write loads the frame RULE18 RULE1 RULE12
					if (wr_buf[p] && active) begin
						tx_sh   <= {1'b1, is11 ? tx_ninth_bit : 1'b1,
							w_byte, 1'b0};
						tx_left <= flen;
					end else if (roll && tx_left != 4'h0) begin
						// Next bit at rollover only RULE4
						tx_out  <= tx_sh[0];
						tx_sh   <= {1'b1, tx_sh[10:1]};
						tx_left <= tx_left - 4'h1;
					end
				end
			end

			// Receiver: edge hunt, vote, shift
			always @(posedge aclk) begin
				if (!aresetn) begin
					rx_on  <= 1'b0;
					rx_div <= 4'h0;
					rx_idx <= 4'h0;
					rx_sh  <= 9'h000;
					smp_a  <= 1'b1;
					smp_b  <= 1'b1;
					prev   <= 1'b1;
				end else begin
					if (tick)
						prev <= pin;
					if (!rx_enable || !active) begin
						// Only while enabled RULE6
						rx_on <= 1'b0;
					end else if (!rx_on) begin
						// Falling edge at 16x rate RULE6 RULE7
						if (tick && prev && !pin) begin
							rx_on  <= 1'b1;
							rx_div <= 4'h0;
							rx_idx <= 4'h0;
						end
					end else if (tick) begin
						rx_div <= rx_div + 4'h1;
						if (rx_div == `ASP_SMP_A)
							smp_a <= pin;
						if (rx_div == `ASP_SMP_B)
							smp_b <= pin;
						if (rx_div == `ASP_SMP_C) begin
							if (rx_idx == 4'h0 && bit_v) begin
								rx_on <= 1'b0; // RULE9
							end else if (last_bit) begin
								rx_on <= 1'b0; // RULE11
							end else begin
								if (rx_idx != 4'h0)
									rx_sh <= {bit_v, rx_sh[8:1]};
								rx_idx <= rx_idx + 4'h1;
							end
						end
					end
				end
			end

			// Readback of this port
			assign ctl_rd[p*8+:8] = {frame_error_access_select ?
				frame_error_flag : mode_select_hi, mode_select_lo,
				address_filter_bit, rx_enable, tx_ninth_bit,
				rx_ninth_bit, transmit_flag, receive_flag};
			assign buf_rd[p*8+:8] = rx_buf;
			assign pin_out[p]     = tx_out;
		end
	endgenerate

	// Pins straight from the transmit flops
	assign serial_out0 = pin_out[0];
	assign serial_out1 = pin_out[1];
endmodule

// ### asp_top_sva.sv
// Bus and serial line assertions for the serial port pair
`timescale 1ns/10ps
module asp_top_sva (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic [7:0]  s_axi_araddr,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0]  s_axi_rresp,
	input logic        s_axi_rvalid,
	input logic        serial_out0
);
	// One clock domain, reset cancels everything
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Address channel closes, then the response shows
	sequence s_wr_done;
		!s_axi_awready ##1 s_axi_bvalid;
	endsequence
	// Start bit stays low for at least eight clocks
	sequence s_start_low;
		!serial_out0 [*8];
	endsequence
	wr_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> s_wr_done) else $error("write answer missing");
	wr_busy_a: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	rd_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	rd_busy_a: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	upper_zero_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	unmapped_rd_a: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	mapped_rd_a: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h10
		&& s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == 2'h0)
		else $error("mapped read refused");
	start_len_a: assert property (
		$fell(serial_out0) |-> s_start_low)
		else $error("start bit too short");
endmodule
bind asp_top asp_top_sva u_sva (.*);

// ### asp_peer.sv
// Remote serial device: sends and captures asynchronous frames
`timescale 1ns/10ps
module asp_peer #(
	parameter integer BIT = 640
) (
	input  logic rx_line,
	output logic tx_line
);
	// Line idles high between frames
	initial tx_line = 1'h1;
	// Start bit, n data bits LSB first, then the stop level
	task send(input [8:0] d, input integer n, input logic stp);
		integer i;
		begin
			#3 tx_line = 1'h0;
			#BIT;
			for (i = 0; i < n; i = i + 1) begin
				tx_line = d[i];
				#BIT;
			end
			tx_line = stp;
			#BIT;
			tx_line = 1'h1;
			#BIT;
		end
	endtask
	// Low pulse shorter than half a bit, then idle
	task glitch(input integer w);
		begin
			#3 tx_line = 1'h0;
			#w;
			tx_line = 1'h1;
			#(BIT * 2);
		end
	endtask
	// Capture each bit at its middle
	task recv(output [8:0] d, input integer n, output logic stp);
		integer i;
		begin
			d = 9'h000;
			@(negedge rx_line);
			#(BIT / 2);
			for (i = 0; i < n; i = i + 1) begin
				#BIT;
				d[i] = rx_line;
			end
			#BIT;
			stp = rx_line;
		end
	endtask
endmodule

// ### tb_async_serial_port_modes_1_2_3.sv
// Self-checking bench for the serial port pair
`timescale 1ns/10ps
`define CHK(g, e) begin \
	samples_checked = samples_checked + 1; \
	if ((g) !== (e)) begin \
		bad_count = bad_count + 1; \
		$display("unexpected at %0t got %h want %h", $time, g, e); \
	end \
end
module tb_async_serial_port_modes_1_2_3;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic        timer_overflow = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire         s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         serial_in0, serial_in1, serial_out0, serial_out1;
	logic [31:0] rdat;       // Last read data
	logic [1:0]  rsp;        // Last response code
	int          bad_count = 0;
	int          samples_checked = 0;
	asp_top u_dut (.*);
	asp_peer u_peer0 (.rx_line(serial_out0), .tx_line(serial_in0));
	asp_peer u_peer1 (.rx_line(serial_out1), .tx_line(serial_in1));
	// 50 MHz clock; overflow every second cycle gives 32-clock bits
	always #10 aclk = ~aclk;
	always @(posedge aclk) timer_overflow <= ~timer_overflow;
	// Bus write, both channels offered together
	task wr(input [7:0] a, input [7:0] d);
		integer n;
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h0, d};
			s_axi_wstrb <= 4'hF;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			for (n = 0; n < 50; n = n + 1) begin
				@(posedge aclk);
				if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
				if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
				if (s_axi_bvalid && s_axi_bready) begin
					rsp = s_axi_bresp;
					s_axi_bready <= 1'h0;
					n = 99;
				end
			end
			// Wait limit ran out
			if (n == 50)
				bad_count = bad_count + 1;
		end
	endtask
	// Bus read
	task rd(input [7:0] a);
		integer n;
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			for (n = 0; n < 50; n = n + 1) begin
				@(posedge aclk);
				if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
				if (s_axi_rvalid && s_axi_rready) begin
					rdat = s_axi_rdata;
					rsp = s_axi_rresp;
					s_axi_rready <= 1'h0;
					n = 99;
				end
			end
			// Wait limit ran out
			if (n == 50)
				bad_count = bad_count + 1;
		end
	endtask
	// Reset values and unmapped place
	task t_reset;
		begin
			rd(8'h00);
			`CHK(rdat, 32'h0);
			rd(8'h14);
			`CHK(rsp, 2'h2);
			wr(8'h14, 8'hFF);
			`CHK(rsp, 2'h2);
		end
	endtask
	// Send one byte out of a port, capture it, check the flag
	task t_tx(input [7:0] co, input [7:0] ctl, input [7:0] d,
		input integer n, input [8:0] e);
		logic [8:0] g;
		logic       s;
		begin
			wr(co, ctl);
			fork
				begin
					if (co == 8'h00) u_peer0.recv(g, n, s);
					else u_peer1.recv(g, n, s);
				end
				wr(co + 8'h04, d);
			join
			`CHK(g, e);
			`CHK(s, 1'h1);
			rd(co);
			`CHK(rdat[7:0], ctl | 8'h02);
		end
	endtask
	// Receive one frame on port 0, check buffer and control
	task t_rx(input [7:0] ctl, input [8:0] d, input integer n,
		input logic stp, input [7:0] eb, input [7:0] ec);
		begin
			if (ctl != 8'h00) wr(8'h00, ctl);
			u_peer0.send(d, n, stp);
			rd(8'h04);
			`CHK(rdat[7:0], eb);
			rd(8'h00);
			`CHK(rdat[7:0], ec);
		end
	endtask
	// Verdict and end of run
	task report_and_stop;
		begin
			$display("mismatches %0d checks %0d", bad_count, samples_checked);
			if (bad_count == 0 && samples_checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// Hang guard
	initial begin
		#1000000;
		bad_count = bad_count + 1;
		report_and_stop;
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset;
		wr(8'h10, 8'h80);
		t_tx(8'h00, 8'h80, 8'hA5, 8, 9'h0A5);
		t_tx(8'h00, 8'h48, 8'h5A, 9, 9'h15A);
		t_tx(8'h00, 8'hC0, 8'h3C, 9, 9'h03C);
		t_tx(8'h08, 8'h48, 8'hC3, 9, 9'h1C3);
		t_rx(8'h90, 9'h03C, 8, 1'h1, 8'h3C, 8'h95);
		t_rx(8'h00, 9'h077, 8, 1'h1, 8'h3C, 8'h95);
		t_rx(8'h50, 9'h1C3, 9, 1'h1, 8'hC3, 8'h55);
		t_rx(8'h70, 9'h0AA, 9, 1'h0, 8'hC3, 8'h70);
		wr(8'h10, 8'hC0);
		rd(8'h00);
		`CHK(rdat[7:0], 8'hF0);
		t_rx(8'hF0, 9'h0AA, 9, 1'h1, 8'hAA, 8'hF1);
		wr(8'h00, 8'h50);
		rd(8'h00);
		`CHK(rdat[7:0], 8'h50);
		// False start: short low pulse must not load a frame
		u_peer0.glitch(100);
		rd(8'h00);
		`CHK(rdat[7:0], 8'h50);
		// Receiver hunts again after the abort
		t_rx(8'h00, 9'h155, 9, 1'h1, 8'h55, 8'h55);
		report_and_stop;
	end
endmodule
